// File: verilog/rpg_pkg.sv
// rpg_pkg: offsets, layouts and reset values of the rail power-good and fault status registers
// assumes: 8-bit register space reached through the device's register port, one clock
package rpg_pkg;
    localparam int          DATA_W          = 8;     // register width
    localparam int          ADDR_W          = 8;     // register address width
    localparam logic [7:0]  GOOD_A_OFFSET   = 8'hb0; // rail_good_status_a
    localparam logic [7:0]  GOOD_B_OFFSET   = 8'hb1; // rail_good_status_b
    localparam logic [7:0]  FAULT_A_OFFSET  = 8'hb2; // rail_fault_status_a
    localparam logic [7:0]  FAULT_B_OFFSET  = 8'hb3; // rail_fault_status_b
    localparam logic [7:0]  GOOD_A_RESET    = 8'h00;
    localparam logic [7:0]  GOOD_B_RESET    = 8'h00;
    localparam logic [7:0]  FAULT_A_RESET   = 8'h00;
    localparam logic [7:0]  FAULT_B_RESET   = 8'h00;
    localparam logic [7:0]  GOOD_A_MASK     = 8'hff; // all eight bits live
    localparam logic [7:0]  GOOD_B_MASK     = 8'h3f; // bits 7:6 reserved
    localparam logic [7:0]  FAULT_A_MASK    = 8'hff; // all eight bits live
    localparam logic [7:0]  FAULT_B_MASK    = 8'h1f; // bits 7:5 reserved
    localparam logic [7:0]  READ_ZERO       = 8'h00; // unmapped and reserved reads
endpackage

// File: verilog/rpg_sticky_flags.sv
// rpg_sticky_flags: one bank of sticky fault flags with write-one-to-clear
// assumes: set inputs are synchronous to i_clk, clear is a one-cycle write strobe
`timescale 1ns/1ps
module rpg_sticky_flags #(
    parameter int         WIDTH      = 8,
    parameter logic [7:0] LIVE_MASK  = 8'hff,
    parameter logic [7:0] RESET_VAL  = 8'h00
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic [WIDTH-1:0]  i_set,       // fault events, one per rail
    input  wire logic              i_clear_we,  // host write strobe to this register
    input  wire logic [WIDTH-1:0]  i_clear_dat, // host write data, ones clear
    output logic      [WIDTH-1:0]  o_flags      // sticky flags
);
    logic [WIDTH-1:0] next_flags; // next sticky value

    // ones in write data clear, zeros keep; set beats clear
    always_comb
    begin
        next_flags = o_flags;
        if (i_clear_we)
        begin
            next_flags = next_flags & ~i_clear_dat;
        end
        next_flags = (next_flags | i_set) & LIVE_MASK[WIDTH-1:0];
    end

    // registers only
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_flags <= RESET_VAL[WIDTH-1:0];
        end
        else
        begin
            o_flags <= next_flags;
        end
    end
endmodule // rpg_sticky_flags

// File: verilog/rpg_status_bank.sv
// rpg_status_bank: power-good status registers for all rails, sticky power-fault status for all but the five-volt ldo
// assumes: rail regulation comparators arrive asynchronously; register port is synchronous
`timescale 1ns/1ps
module rpg_status_bank (
    input  wire logic                          i_clk,
    input  wire logic                          i_reset_n,
    input  wire logic [7:0]                    i_rail_in_reg_a, // raw in-regulation, bank a layout
    input  wire logic [5:0]                    i_rail_in_reg_b, // raw in-regulation, bank b layout
    input  wire logic                          i_reg_wr,        // register write strobe
    input  wire logic                          i_reg_rd,        // register read strobe
    input  wire logic [rpg_pkg::ADDR_W-1:0]    i_reg_addr,      // register address
    input  wire logic [rpg_pkg::DATA_W-1:0]    i_reg_wdata,     // write data
    output logic      [rpg_pkg::DATA_W-1:0]    o_reg_rdata,     // read data, registered
    output logic                               o_reg_rvalid,    // read data valid pulse
    output logic      [7:0]                    o_good_a,        // rail_good_status_a
    output logic      [7:0]                    o_good_b,        // rail_good_status_b
    output logic      [7:0]                    o_fault_a,       // rail_fault_status_a
    output logic      [7:0]                    o_fault_b        // rail_fault_status_b
);
    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers and loss-of-regulation edges
    logic [13:0] sync1;       // first stage, read only by sync2
    logic [13:0] sync2;       // second stage
    logic [13:0] next_sync1;
    logic [13:0] next_sync2;
    logic [13:0] good_now;    // synchronised live status
    logic [13:0] lost;        // falling edge of regulation
    logic [7:0]  next_good_a;
    logic [7:0]  next_good_b;

    logic [13:0] held_good;   // previous synchronised status as held in the registers

    assign held_good = {o_good_b[5:0], o_good_a};
    assign good_now  = sync2;
    // a fault is a good rail dropping out; a rail that never came up is not a fault
    assign lost      = held_good & ~good_now;

    // next values of synchroniser and live good registers
    always_comb
    begin
        next_sync1  = {i_rail_in_reg_b, i_rail_in_reg_a};
        next_sync2  = sync1;
        next_good_a = good_now[7:0] & rpg_pkg::GOOD_A_MASK;
        next_good_b = {2'b00, good_now[13:8]} & rpg_pkg::GOOD_B_MASK;
    end

    // registers only; good registers ignore writes entirely
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sync1    <= 14'h0000;
            sync2    <= 14'h0000;
            o_good_a <= rpg_pkg::GOOD_A_RESET;
            o_good_b <= rpg_pkg::GOOD_B_RESET;
        end
        else
        begin
            sync1    <= next_sync1;
            sync2    <= next_sync2;
            o_good_a <= next_good_a;
            o_good_b <= next_good_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky fault banks
    logic wr_fault_a; // write strobe decoded to fault a
    logic wr_fault_b; // write strobe decoded to fault b
    assign wr_fault_a = i_reg_wr && (i_reg_addr == rpg_pkg::FAULT_A_OFFSET);
    assign wr_fault_b = i_reg_wr && (i_reg_addr == rpg_pkg::FAULT_B_OFFSET);

    // bank a: ldo a2, switch a, six step-down rails
    rpg_sticky_flags #(
        .WIDTH     (8),
        .LIVE_MASK (rpg_pkg::FAULT_A_MASK),
        .RESET_VAL (rpg_pkg::FAULT_A_RESET)
    ) u_fault_a (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_set       (lost[7:0]),
        .i_clear_we  (wr_fault_a),
        .i_clear_dat (i_reg_wdata),
        .o_flags     (o_fault_a)
    );

    // bank b: five rails; the five-volt ldo has no fault bit
    rpg_sticky_flags #(
        .WIDTH     (8),
        .LIVE_MASK (rpg_pkg::FAULT_B_MASK),
        .RESET_VAL (rpg_pkg::FAULT_B_RESET)
    ) u_fault_b (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_set       ({3'b000, lost[12:8]}),
        .i_clear_we  (wr_fault_b),
        .i_clear_dat (i_reg_wdata),
        .o_flags     (o_fault_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read port: one cycle after the strobe, unmapped reads zero
    logic [7:0] next_rdata;
    logic       next_rvalid;

    // read mux
    always_comb
    begin
        next_rdata  = o_reg_rdata;
        next_rvalid = i_reg_rd;
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                rpg_pkg::GOOD_A_OFFSET:  next_rdata = o_good_a;
                rpg_pkg::GOOD_B_OFFSET:  next_rdata = o_good_b;
                rpg_pkg::FAULT_A_OFFSET: next_rdata = o_fault_a;
                rpg_pkg::FAULT_B_OFFSET: next_rdata = o_fault_b;
                default:                 next_rdata = rpg_pkg::READ_ZERO;
            endcase
        end
    end

    // registers only
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_reg_rdata  <= rpg_pkg::READ_ZERO;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rdata  <= next_rdata;
            o_reg_rvalid <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_good_follows;
        @(posedge i_clk) disable iff (!i_reset_n)
        ##1 ({o_good_b[5:0], o_good_a} == $past(sync2));
    endproperty
    a_good_follows: assert property (p_good_follows) else $error("good bits do not follow rails");

    property p_good_reserved;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_good_b[7:6] == 2'b00;
    endproperty
    a_good_reserved: assert property (p_good_reserved) else $error("good reserved bits set");

    property p_good_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        (sync2[0] == 1'b0) |=> (o_good_a[0] == 1'b0);
    endproperty
    a_good_off: assert property (p_good_off) else $error("good bit high while rail out");

    property p_fault_sets;
        @(posedge i_clk) disable iff (!i_reset_n)
        lost[7:0] != 8'h00 |=> ((o_fault_a & $past(lost[7:0])) == $past(lost[7:0]));
    endproperty
    a_fault_sets: assert property (p_fault_sets) else $error("fault a not set on loss");

    property p_fault_holds;
        @(posedge i_clk) disable iff (!i_reset_n)
        !wr_fault_a |=> ((o_fault_a & $past(o_fault_a)) == $past(o_fault_a));
    endproperty
    a_fault_holds: assert property (p_fault_holds) else $error("fault a dropped without clear");

    property p_fault_clears;
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_fault_b |=> ((o_fault_b & $past(i_reg_wdata) & ~{3'b000, $past(lost[12:8])}) == 8'h00);
    endproperty
    a_fault_clears: assert property (p_fault_clears) else $error("fault b not cleared by one");

    property p_set_wins;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_fault_a && lost[0]) |=> o_fault_a[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a new fault");

    property p_fault_reserved;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_fault_b[7:5] == 3'b000;
    endproperty
    a_fault_reserved: assert property (p_fault_reserved) else $error("fault reserved bits set");

    property p_unmapped_zero;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_reg_rd && (i_reg_addr < rpg_pkg::GOOD_A_OFFSET || i_reg_addr > rpg_pkg::FAULT_B_OFFSET))
            |=> (o_reg_rvalid && o_reg_rdata == 8'h00);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_read_fault;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_reg_rd && i_reg_addr == rpg_pkg::FAULT_A_OFFSET) |=> (o_reg_rdata == $past(o_fault_a));
    endproperty
    a_read_fault: assert property (p_read_fault) else $error("fault a read wrong");

    // bank b rails out of regulation must read zero one edge later
    property p_good_b_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        (sync2[13:8] == 6'h00) |=> (o_good_b == 8'h00);
    endproperty
    a_good_b_off: assert property (p_good_b_off) else $error("good b bits high while rails out");

    // zeros in a clear write leave recorded faults in place
    property p_zero_keeps;
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_fault_b |=> ((o_fault_b & $past(o_fault_b & ~i_reg_wdata)) == $past(o_fault_b & ~i_reg_wdata));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared a fault");

    c_fault_seen:  cover property (@(posedge i_clk) disable iff (!i_reset_n) o_fault_a != 8'h00);
    c_clear_done:  cover property (@(posedge i_clk) disable iff (!i_reset_n) o_fault_b[0] ##1 !o_fault_b[0]);
    c_set_and_clr: cover property (@(posedge i_clk) disable iff (!i_reset_n) wr_fault_a && lost[0]);
endmodule // rpg_status_bank

// File: bench/rpg_host_model.sv
// rpg_host_model: host side of the status register port, one access at a time
// assumes: tasks are entered just after a rising edge of i_clk
`timescale 1ns/1ps
module rpg_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_rvalid,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr    = 1'b0,
    output logic            o_rd    = 1'b0,
    output logic      [7:0] o_addr  = 8'h00,
    output logic      [7:0] o_wdata = 8'h00
);
    ////////////////////////////////////////////////////////////////////////////
    // write: one edge of gap first, so a strobe never drops and rises at once
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1; // ones acknowledge faults
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a; // released lines do not keep the last value
        o_wdata = ~d;
    endtask
    // read: answer is taken at the edge after the strobe edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx; // missing valid is a mismatch
    endtask
endmodule // rpg_host_model

// File: bench/rpg_status_bank_tb_top.sv
// rpg_status_bank_tb_top: random rail and register traffic against an integer model
// assumes: good regs settle within 4 edges of a rail change, faults within 5
`timescale 1ns/1ps
module rpg_status_bank_tb_top;
    logic       clk;
    logic       reset_n = 1'b0;
    logic [7:0] rail_a  = 8'h00;
    logic [5:0] rail_b  = 6'h00;
    logic       wr, rd, rvalid;
    logic [7:0] addr, wdata, rdata, good_a, good_b, fault_a, fault_b, wa, wd;
    int         bad_count = 0, comparisons = 0, seed = 32'h02e718c5;
    int         exp_good_a = 0, exp_good_b = 0, exp_fault_a = 0, exp_fault_b = 0;
    ////////////////////////////////////////////////////////////////////////////
    rpg_status_bank u_dut (.i_clk(clk), .i_reset_n(reset_n), .i_rail_in_reg_a(rail_a),
        .i_rail_in_reg_b(rail_b), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_good_a(good_a),
        .o_good_b(good_b), .o_fault_a(fault_a), .o_fault_b(fault_b));
    rpg_host_model u_host (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input int exp);
        comparisons++;
        if (seen !== exp[7:0])
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp[7:0], seen);
        end
    endtask
    // read one register through the host model and compare the returned byte
    task automatic check_read(input logic [7:0] a, input int exp);
        logic [7:0] d;
        u_host.read(a, d);
        comparisons++;
        if (d !== exp[7:0])
        begin
            bad_count++;
            $display("CHECK FAILED rdata %h expected %h seen %h", a, exp[7:0], d);
        end
    endtask
    // new rail levels; model: a rail that was good and drops records a fault
    task automatic set_rails(input logic [7:0] a, input logic [5:0] b);
        rail_a = a;
        rail_b = b;
        repeat (5) @(posedge clk);
        #1;
        exp_fault_a |= exp_good_a & ~int'(a);
        exp_fault_b |= exp_good_b & ~int'(b) & 'h1f; // five volt rail has no fault bit
        exp_good_a = a;
        exp_good_b = b;
    endtask
    // outputs and read-back of all four registers plus an unmapped place
    task automatic check_all();
        int         exp[5];
        logic [7:0] adr[5];
        exp = '{exp_good_a, exp_good_b, exp_fault_a, exp_fault_b, 0};
        adr = '{rpg_pkg::GOOD_A_OFFSET, rpg_pkg::GOOD_B_OFFSET, rpg_pkg::FAULT_A_OFFSET,
                rpg_pkg::FAULT_B_OFFSET, 8'hc5};
        check("good_a", good_a, exp_good_a);
        check("good_b", good_b, exp_good_b);
        check("fault_a", fault_a, exp_fault_a);
        check("fault_b", fault_b, exp_fault_b);
        for (int i = 0; i < 5; i++)
        begin
            check_read(adr[i], exp[i]);
        end
    endtask
    // one write, mirrored in the model; only ones clear, other places ignore it
    task automatic host_write(input logic [7:0] a, input logic [7:0] d);
        u_host.write(a, d);
        if (a == rpg_pkg::FAULT_A_OFFSET)
            exp_fault_a &= ~int'(d);
        if (a == rpg_pkg::FAULT_B_OFFSET)
            exp_fault_b &= ~int'(d);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        check_all();
        set_rails(8'hff, 6'h3f);
        check_all();
        set_rails(8'h00, 6'h00);
        check_all();
        host_write(8'hb2, 8'h00);
        host_write(8'hb0, 8'hff);
        host_write(8'hb1, 8'hff);
        host_write(8'hb3, 8'hff);
        host_write(8'hb2, 8'h0f);
        check_all();
        set_rails(8'hff, 6'h3f);
        // fault lands on the same edge as a clear of that bit
        rail_a = 8'hfe;
        repeat (1) @(posedge clk);
        #1;
        u_host.write(8'hb2, 8'h01);
        exp_fault_a |= 1;
        exp_good_a = 'hfe;
        check_all();
        for (int n = 0; n < 25; n++)
        begin
            set_rails(8'($random(seed)), 6'($random(seed)));
            check_all();
            wa = 8'hb0 + 8'($random(seed) & 7);
            wd = 8'($random(seed));
            host_write(wa, wd);
        end
        // second reset in mid-run clears faults; live rails come back as good
        reset_n = 1'b0;
        @(posedge clk);
        #1;
        reset_n = 1'b1;
        exp_fault_a = 0;
        exp_fault_b = 0;
        repeat (5) @(posedge clk);
        #1;
        check_all();
        results();
    end
    // watchdog at 16000 cycles, well beyond the roughly 530 cycles the sequence needs
    initial
    begin
        #400000;
        bad_count++;
        results();
    end
endmodule // rpg_status_bank_tb_top
